// *** core/bridge_pkg.sv ***
// bridge_pkg: register offsets, field positions, reset values and timing
// counts for the controller-to-internal-bus bridge.
// assumes a single 250 MHz controller clock.
package bridge_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [2:0] OFF_OFFSET   = 3'h0;
  localparam logic [2:0] OFF_DATA     = 3'h1;
  localparam logic [2:0] OFF_LOCK     = 3'h2;
  localparam logic [2:0] OFF_VIOL     = 3'h3;
  localparam logic [2:0] OFF_ENABLE   = 3'h4;
  localparam logic [2:0] OFF_CONTROL  = 3'h5;
  // target-select bit positions
  localparam int BIT_CFG_AE  = 0;
  localparam int BIT_CLK_AE  = 1;
  localparam int BIT_WAKE_AE = 2;
  // control bit positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_RD_START  = 1;
  localparam int BIT_WR_PEND   = 2;
  localparam int BIT_CLK_RST   = 3;
  // lock and violation bit positions
  localparam int BIT_LOCK_CFG = 0;
  localparam int BIT_LOCK_CLK = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // clock-module register pair index bases
  localparam logic [7:0] CLK_PAIR_LO = 8'h70;
  localparam logic [7:0] CLK_PAIR_HI = 8'h72;
  // timing
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int RST_PULSE_NS      = 16;
  localparam int RST_PULSE_CYCLES  = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W             = 4;
  // bridge cycle states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_BUSY  = 2'b10
  } bridge_state_e;
endpackage

// *** core/host_module_indirect_bridge.sv ***
// host_module_indirect_bridge: controller-side bridge onto the internal host bus,
// with lock and violation registers for host access.
// assumes the internal bus targets answer with a one-cycle ack on clk, and that
// host bus requests and host lock-violation events arrive synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module host_module_indirect_bridge
  import bridge_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // internal bus, controller side
  output logic            ibus_req,
  output logic            ibus_we,
  output logic      [2:0] ibus_sel,
  output logic      [7:0] ibus_addr,
  output logic      [7:0] ibus_wdata,
  input  wire logic [7:0] ibus_rdata,
  input  wire logic       ibus_ack,
  // host side of the arbiter
  input  wire logic       host_req,
  input  wire logic       host_done,
  output logic            host_grant,
  // host accesses that hit a module, for lock checking
  input  wire logic       host_cfg_access,
  input  wire logic       host_clk_access,
  output logic      [1:0] host_lock,
  // reset pulse into the clock module
  output logic            clk_module_reset
);

  logic [7:0]    indirect_offset_reg;
  logic [7:0]    indirect_data_reg;
  logic [1:0]    host_lock_register;
  logic [1:0]    lock_violation_flags;
  logic [2:0]    target_module_access_enable;
  logic          bridge_global_enable;
  logic          read_cycle_start_pending;
  logic          write_cycle_pending;
  logic          clock_module_reset_pulse;
  logic [CNT_W-1:0] rst_cnt;
  bridge_state_e state;
  bridge_state_e next_state;
  logic          host_owns;

  // cycle walk, counted from the register write edge c0:
  //   c1 pending bit set, c2 state busy, c3 request on the bus
  //   ack at cn, then at cn+1 pending clear and request dropped
  // a read also lands the returned byte in the data register at cn+1
  // firmware polls the pending bits; this block never stalls the port
  // hazard: a data write while a cycle pends is dropped, so the bus
  //   never sees a byte that changed mid-cycle
  // hazard: a host grant and a bridge data write in one cycle go to the
  //   bridge, which keeps first-come fair at the tie
  // limitation: an illegal target mix simply never reaches the bus;
  //   the data byte is still stored so firmware can read it back
  // trade-off: all bus outputs are flops, one cycle of latency for
  //   clean timing towards the host-side modules
  // the clock reset pulse is counted on clk, so its width tracks the clock

  // exactly one target bit set
  function automatic logic one_hot3(input logic [2:0] v);
    one_hot3 = (v == 3'b001) || (v == 3'b010) || (v == 3'b100);
  endfunction

  // register-port write decode, shared by the data, violation and control strobes
  function automatic logic reg_write_hit(input logic       wr,
                                         input logic [2:0] addr,
                                         input logic [2:0] off);
    reg_write_hit = wr && (addr == off);
  endfunction

  // clock target: offset bit 1 picks the pair, bit 0 the index or data port
  function automatic logic [7:0] clk_pair_addr(input logic [7:0] off);
    clk_pair_addr = (off[1] ? CLK_PAIR_HI : CLK_PAIR_LO) | {7'h00, off[0]};
  endfunction

  // a write to the data register or a 1 to the read bit asks for a cycle
  logic wr_data_hit;
  logic wr_ctl_hit;
  logic cycle_ok;
  assign wr_data_hit = reg_write_hit(reg_wr, reg_addr, OFF_DATA);
  assign wr_ctl_hit  = reg_write_hit(reg_wr, reg_addr, OFF_CONTROL);
  assign cycle_ok    = bridge_global_enable && one_hot3(target_module_access_enable);

  // plain read/write registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_offset_reg         <= RST_BYTE;
      host_lock_register          <= 2'b00;
      target_module_access_enable <= 3'b000;
      bridge_global_enable        <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_OFFSET:  indirect_offset_reg <= reg_wdata;
        OFF_LOCK:    host_lock_register  <= reg_wdata[1:0];
        OFF_ENABLE:  target_module_access_enable <= reg_wdata[2:0];
        OFF_CONTROL: bridge_global_enable <= reg_wdata[BIT_GLOBAL_EN];
        default: ;
      endcase
    end
  end

  // violation flags: a host hit on a locked module wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_violation_flags <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == BIT_LOCK_CFG ? host_cfg_access : host_clk_access) && host_lock_register[i])
          lock_violation_flags[i] <= 1'b1;
        else if (reg_write_hit(reg_wr, reg_addr, OFF_VIOL) && reg_wdata[i])
          lock_violation_flags[i] <= 1'b0;
      end
    end
  end

  // first-come host ownership; a bridge data write in the same cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_owns <= 1'b0;
    end else if (!host_owns && host_req && state == ST_IDLE
                 && !(wr_data_hit && cycle_ok)) begin
      host_owns <= 1'b1;
    end else if (host_owns && host_done) begin
      host_owns <= 1'b0;
    end
  end

  // next bridge state; a pending cycle parks in wait while the host holds the bus
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if ((write_cycle_pending || read_cycle_start_pending) && cycle_ok) begin
          next_state = host_owns ? ST_WAIT : ST_BUSY;
        end
      end
      ST_WAIT: begin
        if (!host_owns) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (ibus_ack) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // bridge cycle state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // data register and the two pending bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_data_reg        <= RST_BYTE;
      write_cycle_pending      <= 1'b0;
      read_cycle_start_pending <= 1'b0;
    end else begin
      if (wr_data_hit && !write_cycle_pending && !read_cycle_start_pending) begin
        indirect_data_reg   <= reg_wdata;
        write_cycle_pending <= cycle_ok;
      end else if (state == ST_BUSY && ibus_ack && write_cycle_pending) begin
        write_cycle_pending <= 1'b0;
      end
      if (state == ST_BUSY && ibus_ack && read_cycle_start_pending) begin
        indirect_data_reg        <= ibus_rdata;
        read_cycle_start_pending <= 1'b0;
      end else if (wr_ctl_hit && reg_wdata[BIT_RD_START] && cycle_ok && !write_cycle_pending) begin
        read_cycle_start_pending <= 1'b1;
      end
    end
  end

  // clock-module reset pulse; writing 0 leaves it alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_module_reset_pulse <= 1'b0;
      rst_cnt                  <= '0;
    end else if (clock_module_reset_pulse) begin
      if (rst_cnt == CNT_W'(RST_PULSE_CYCLES - 1))
        clock_module_reset_pulse <= 1'b0;
      rst_cnt <= rst_cnt + 1'b1;
    end else if (wr_ctl_hit && reg_wdata[BIT_CLK_RST]) begin
      clock_module_reset_pulse <= 1'b1;
      rst_cnt                  <= '0;
    end
  end

  // request lives in busy and drops the edge after ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ibus_req <= 1'b0;
      ibus_we  <= 1'b0;
    end else begin
      ibus_req <= (state == ST_BUSY) && !ibus_ack;
      ibus_we  <= write_cycle_pending;
    end
  end

  // target select follows the enable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ibus_sel <= 3'b000;
    end else begin
      ibus_sel <= target_module_access_enable;
    end
  end

  // address from the held offset; clock target folds onto its index pairs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ibus_addr <= RST_BYTE;
    end else if (target_module_access_enable[BIT_CLK_AE]) begin
      ibus_addr <= clk_pair_addr(indirect_offset_reg);
    end else begin
      ibus_addr <= indirect_offset_reg;
    end
  end

  // write data straight from the data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ibus_wdata <= RST_BYTE;
    end else begin
      ibus_wdata <= indirect_data_reg;
    end
  end

  // side outputs, registered so every pin comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_grant       <= 1'b0;
      host_lock        <= 2'b00;
      clk_module_reset <= 1'b0;
    end else begin
      host_grant       <= host_owns;
      host_lock        <= host_lock_register;
      clk_module_reset <= clock_module_reset_pulse;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_BYTE;
    end else begin
      reg_rdata <= RST_BYTE;
      if (reg_rd) begin
        case (reg_addr)
          OFF_OFFSET:  reg_rdata <= indirect_offset_reg;
          OFF_DATA:    reg_rdata <= indirect_data_reg;
          OFF_LOCK:    reg_rdata <= {6'h00, host_lock_register};
          OFF_VIOL:    reg_rdata <= {6'h00, lock_violation_flags};
          OFF_ENABLE:  reg_rdata <= {5'h00, target_module_access_enable};
          OFF_CONTROL: reg_rdata <= {4'h0, clock_module_reset_pulse, write_cycle_pending,
                                     read_cycle_start_pending, bridge_global_enable};
          default:     reg_rdata <= RST_BYTE;
        endcase
      end
    end
  end

endmodule // host_module_indirect_bridge
`default_nettype wire

// *** testbench/host_module_indirect_bridge_asserts.sv ***
// checker for the bridge top-level ports, bound into every instance
// assumes one clock domain with rst_n asynchronous and active low
`timescale 1ns/1ps
`default_nettype none
module host_module_indirect_bridge_asserts
  import bridge_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ibus_req,
  input wire logic       ibus_we,
  input wire logic [2:0] ibus_sel,
  input wire logic [7:0] ibus_addr,
  input wire logic       ibus_ack,
  input wire logic       host_grant,
  input wire logic       clk_module_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // reset request and the four-cycle pulse it must produce
  sequence rst_req_s;
    reg_wr && reg_addr == OFF_CONTROL && reg_wdata[BIT_CLK_RST] && !clk_module_reset;
  endsequence
  sequence rst_pulse_s;
    clk_module_reset [*4] ##1 !clk_module_reset;
  endsequence
  a_req_ends_ack: assert property (ibus_req && ibus_ack |=> !ibus_req)
    else $error("bus request outlived its ack");
  a_req_holds: assert property (ibus_req && !ibus_ack |=>
    ibus_req && $stable(ibus_addr) && $stable(ibus_we))
    else $error("bus cycle changed before ack");
  a_one_target: assert property (ibus_req |-> $onehot(ibus_sel))
    else $error("bus cycle without exactly one target");
  a_bus_exclusive: assert property (host_grant |-> !ibus_req)
    else $error("host and bridge own the bus together");
  a_clock_pair: assert property (ibus_req && ibus_sel[BIT_CLK_AE] |->
    ibus_addr[7:2] == CLK_PAIR_LO[7:2])
    else $error("clock cycle outside the index pairs");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_rst_launch: assert property (rst_req_s |-> ##2 rst_pulse_s)
    else $error("clock reset pulse not launched");
  a_rst_length: assert property ($rose(clk_module_reset) |-> rst_pulse_s)
    else $error("clock reset pulse has wrong length");
endmodule // host_module_indirect_bridge_asserts
bind host_module_indirect_bridge host_module_indirect_bridge_asserts i_chk (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ibus_req,
  .ibus_we, .ibus_sel, .ibus_addr, .ibus_ack, .host_grant, .clk_module_reset
);
`default_nettype wire

// *** testbench/ibus_target_model.sv ***
// far-side target model: answers each bridge cycle after dly cycles
// assumes the bridge holds its request until the one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module ibus_target_model (
  input  wire logic       clk,
  input  wire logic       ibus_req,
  input  wire logic [2:0] ibus_sel,
  input  wire logic [7:0] ibus_addr,
  input  wire logic [3:0] dly,
  output var  logic [7:0] ibus_rdata,
  output var  logic       ibus_ack
);
  logic [3:0] cnt;
  initial {ibus_ack, ibus_rdata, cnt} = '0;
  // data churns between answers so a stale byte is never trusted
  always @(posedge clk) begin
    ibus_ack   <= 1'b0;
    ibus_rdata <= ~ibus_rdata;
    if (ibus_req && !ibus_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= dly) begin
        ibus_ack   <= 1'b1;
        ibus_rdata <= ibus_addr ^ 8'h5a ^ {5'h0, ibus_sel};
        cnt        <= 4'h0;
      end
    end
  end
endmodule // ibus_target_model
`default_nettype wire

// *** testbench/host_module_indirect_bridge_tb.sv ***
// top bench: register driver, result monitor and bus target model
// assumes reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module host_module_indirect_bridge_tb;
  import bridge_pkg::*;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_chk = 0, rd_d = 0;
  logic        host_req = 0, host_done = 0, host_cfg_access = 0, host_clk_access = 0;
  logic        ibus_req, ibus_we, ibus_ack, host_grant, clk_module_reset;
  logic [2:0]  reg_addr = 0, ibus_sel;
  logic [7:0]  reg_wdata = 0, reg_rdata, ibus_addr, ibus_wdata, ibus_rdata, a, d, ea;
  logic [1:0]  host_lock;
  logic [3:0]  dly = 0;
  logic [31:0] seed = 76;
  logic [19:0] rq[$], bq[$];
  int          n_mismatch = 0, num_checks = 0;
  host_module_indirect_bridge i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ibus_req, .ibus_we, .ibus_sel, .ibus_addr, .ibus_wdata,
    .ibus_rdata, .ibus_ack, .host_req, .host_done, .host_grant, .host_cfg_access,
    .host_clk_access, .host_lock, .clk_module_reset);
  ibus_target_model i_tgt (.clk, .ibus_req, .ibus_sel, .ibus_addr, .dly, .ibus_rdata,
    .ibus_ack);
  initial forever #2 clk = ~clk;
  function automatic logic [7:0] rnd;
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic cyc(int n = 1); repeat (n) @(posedge clk); endtask
  task automatic chk(logic [19:0] g, logic [19:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // strobes drop for a cycle so no signal is driven twice at one edge
  task automatic wr(logic [2:0] ad, logic [7:0] dt);
    reg_addr <= ad; reg_wdata <= dt; reg_wr <= 1; cyc(); reg_wr <= 0; cyc();
  endtask
  task automatic rd(logic [2:0] ad, logic [7:0] ex, bit ck = 1);
    if (ck) rq.push_back(20'(ex));
    reg_addr <= ad; reg_rd <= 1; rd_chk <= ck; cyc(); reg_rd <= 0; #1 a = reg_rdata; cyc();
  endtask
  task automatic poll;
    for (int i = 0; i <= 60; i++) begin
      if (i == 60) begin n_mismatch++; end_of_test; end
      rd(OFF_CONTROL, 8'h00, 0);
      if (a[2:1] === 2'b00) break;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // monitor: oldest note is compared when a result shows; stray cycles fail
  always @(posedge clk) begin
    rd_d <= reg_rd && rd_chk;
    if (rd_d) chk(20'(reg_rdata), rq.pop_front());
    if ((ibus_req & ibus_ack) === 1'b1)
      chk({ibus_we, ibus_sel, ibus_addr, ibus_we ? ibus_wdata : 8'h00},
          bq.size() ? bq.pop_front() : 20'hfffff);
  end
  initial begin cyc(20000); n_mismatch++; end_of_test; end
  initial begin
    cyc(3); rst_n <= 1; cyc();
    for (int r = 0; r < 8; r++) rd(r[2:0], 8'h00);
    wr(OFF_CONTROL, 8'h01);
    rd(OFF_CONTROL, 8'h01);
    // every target, prompt and slow answers, write then read
    for (int t = 0; t < 3; t++) begin
      dly <= 4'(t * 3); d = rnd(); ea = rnd();
      wr(OFF_OFFSET, ea);
      if (t == 1) ea = {6'h1c, ea[1:0]};
      wr(OFF_ENABLE, 8'h01 << t);
      rd(OFF_ENABLE, 8'h01 << t);
      bq.push_back({1'b1, 3'(1 << t), ea, d});
      wr(OFF_DATA, d);
      rd(OFF_CONTROL, 8'h05);
      poll;
      bq.push_back({1'b0, 3'(1 << t), ea, 8'h00});
      wr(OFF_CONTROL, 8'h03);
      rd(OFF_CONTROL, 8'h03);
      poll;
      rd(OFF_DATA, ea ^ 8'h5a ^ 8'(1 << t));
    end
    // no cycle with two targets, no target, or global enable off
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      wr(OFF_CONTROL, {7'h0, k != 2});
      wr(OFF_ENABLE, k == 0 ? 8'h03 : {7'h0, k == 2});
      wr(OFF_DATA, d);
      rd(OFF_CONTROL, {7'h0, k != 2});
      rd(OFF_DATA, d);
    end
    wr(OFF_CONTROL, 8'h09);
    rd(OFF_CONTROL, 8'h09);
    chk(20'(clk_module_reset), 20'h1);
    cyc(6);
    rd(OFF_CONTROL, 8'h01);
    chk(20'(clk_module_reset), 20'h0);
    // host owns the bus first, so the bridge write must wait
    host_req <= 1; cyc(3);
    bq.push_back({1'b1, 3'h4, ea, 8'h3c});
    wr(OFF_ENABLE, 8'h04);
    wr(OFF_DATA, 8'h3c);
    cyc(4);
    chk(ibus_req, 0);
    chk(20'(host_grant), 20'h1);
    host_done <= 1; host_req <= 0; cyc(); host_done <= 0;
    poll;
    wr(OFF_LOCK, 8'h01);
    host_cfg_access <= 1; host_clk_access <= 1; cyc();
    host_cfg_access <= 0; host_clk_access <= 0; cyc();
    chk(host_lock, 1);
    rd(OFF_VIOL, 8'h01);
    wr(OFF_VIOL, 8'h01);
    rd(OFF_VIOL, 8'h00);
    end_of_test;
  end
endmodule // host_module_indirect_bridge_tb
`default_nettype wire
